//--- rtl/lockstep_cfg.svh
/*
 * Positions, widths and timing constants of the lockstep comparison
 * vector and of the debug scan port.
 * Assumes it is included by bare name; definitions only.
 */
`ifndef LOCKSTEP_CFG_SVH
`define LOCKSTEP_CFG_SVH

// ****************************************************************
// Comparison vector layout
// ****************************************************************
`define CMP_VEC_W          4096
`define STREAM_CHANNELS    16
`define STREAM_STRIDE      37
`define STREAM_DATA_W      32
`define STREAM_SCLK_BIT    981
`define STREAM_SRD_BIT     982
`define STREAM_MCLK_BIT    983
`define STREAM_MWR_BIT     984
`define STREAM_WDATA_LO    985
`define STREAM_WDATA_HI    1016
`define STREAM_CTL_BIT     1017
`define DC_WDATA_LO        2906
`define DC_WDATA_HI        3417
`define DC_WDATA_USED_W    32
`define TRACE_LO           3551
`define TRACE_HI           3767
`define RSVD_LO            3768
`define RSVD_HI            4095

// ****************************************************************
// Debug scan port
// ****************************************************************
`define DBG_REG_W          8
`define DBG_CNT_W          4
`define DBG_RST_CYCLES     4'h1
`define DBG_CNT_ZERO       4'h0
`define DBG_CNT_ONE        4'h1

`endif

//--- rtl/lockstep_dbg.sv
/*
 * Debug and checker end: runs capture/shift/update scan cycles on the
 * processor end, issues debug reset, and compares the vector to a reference.
 * Assumes one sys_clk for both ends; requests are one-cycle pulses.
 */
`timescale 1ns/1ps
`include "lockstep_cfg.svh"

module lockstep_dbg
   import lockstep_pkg::*;
(
   input  wire logic                  sys_clk,
   input  wire logic                  rst,
   lockstep_if.dbg                    link,
   input  wire logic                  scan_start,
   input  wire logic [`DBG_REG_W-1:0] scan_wdata,
   input  wire logic                  rst_req,
   input  wire logic [`CMP_VEC_W-1:0] ref_vec,
   output logic                       scan_busy,
   output logic                       scan_done,
   output logic      [`DBG_REG_W-1:0] scan_rdata,
   output logic                       mismatch
);

   localparam logic [`CMP_VEC_W-1:0] CMP_MASK = cmp_mask();

   host_state_t s_q;
   host_state_t s_d;

   // ****************************************************************
   // Scan sequencer
   // ****************************************************************
   always_comb begin
      s_d      = s_q;
      s_d.done = 1'h0;
      case (s_q.st)
         ST_IDLE: begin
            if (rst_req) begin
               s_d.st  = ST_RST_HOLD;
               s_d.cnt = `DBG_CNT_ONE;
            end else if (scan_start) begin
               s_d.st  = ST_CAP_LO;
               s_d.tx  = scan_wdata;
               s_d.cnt = `DBG_CNT_ZERO;
            end
         end
         ST_RST_HOLD: begin
            if (s_q.cnt >= `DBG_RST_CYCLES) begin
               s_d.st = ST_IDLE;
            end else begin
               s_d.cnt = s_q.cnt + `DBG_CNT_ONE;
            end
         end
         ST_CAP_LO:   s_d.st = ST_CAP_HI;
         ST_CAP_HI:   s_d.st = ST_SHIFT_LO;
         ST_SHIFT_LO: s_d.st = ST_SHIFT_HI;
         ST_SHIFT_HI: begin
            s_d.tx  = {1'h0, s_q.tx[`DBG_REG_W-1:1]};
            s_d.rx  = {link.scan_tdo, s_q.rx[`DBG_REG_W-1:1]};
            s_d.cnt = s_q.cnt + `DBG_CNT_ONE;
            if (s_q.cnt == `DBG_CNT_W'(`DBG_REG_W - 1)) begin
               s_d.st = ST_UPD_LO;
            end else begin
               s_d.st = ST_SHIFT_LO;
            end
         end
         ST_UPD_LO:   s_d.st = ST_UPD_HI;
         ST_UPD_HI: begin
            s_d.st    = ST_IDLE;
            s_d.done  = 1'h1;
            s_d.rdata = s_q.rx;
         end
         default:     s_d.st = ST_IDLE;
      endcase

      // phase pin levels
      // Pin levels follow the state being entered, so they leave a flop
      s_d.debug_rst = (s_d.st == ST_RST_HOLD);
      s_d.scan_clk  = (s_d.st == ST_CAP_HI) || (s_d.st == ST_SHIFT_HI) || (s_d.st == ST_UPD_HI);
      s_d.capture   = (s_d.st == ST_CAP_LO) || (s_d.st == ST_CAP_HI);
      s_d.shift     = (s_d.st == ST_SHIFT_LO) || (s_d.st == ST_SHIFT_HI);
      s_d.update    = (s_d.st == ST_UPD_LO) || (s_d.st == ST_UPD_HI);
      s_d.reg_en    = s_d.capture || s_d.shift || s_d.update;
      s_d.busy      = (s_d.st != ST_IDLE);
      s_d.tdi       = s_d.tx[0];

      // Only the used part of each slot is compared
      s_d.mismatch = |((link.compare_vec ^ ref_vec) & CMP_MASK);
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign link.scan_clk     = s_q.scan_clk;
   assign link.scan_tdi     = s_q.tdi;
   assign link.scan_reg_en  = s_q.reg_en;
   assign link.scan_shift   = s_q.shift;
   assign link.scan_capture = s_q.capture;
   assign link.scan_update  = s_q.update;
   assign link.debug_rst    = s_q.debug_rst;
   assign scan_busy         = s_q.busy;
   assign scan_done         = s_q.done;
   assign scan_rdata        = s_q.rdata;
   assign mismatch          = s_q.mismatch;

endmodule

//--- rtl/lockstep_dev.sv
/*
 * Processor end: packs stream, data-cache write and trace signals into the
 * lockstep comparison vector, and holds the debug scan register.
 * Assumes all inputs are synchronous to sys_clk and the scan clock is a
 * sampled strobe produced from sys_clk by the debug end.
 */
`timescale 1ns/1ps
`include "lockstep_cfg.svh"

module lockstep_dev
   import lockstep_pkg::*;
(
   input  wire logic                                            sys_clk,
   input  wire logic                                            rst,
   lockstep_if.dev                                              link,
   input  wire logic [`STREAM_CHANNELS-1:0]                     stream_chan_slave_clk,
   input  wire logic [`STREAM_CHANNELS-1:0]                     stream_chan_slave_rd,
   input  wire logic [`STREAM_CHANNELS-1:0]                     stream_chan_master_clk,
   input  wire logic [`STREAM_CHANNELS-1:0]                     stream_chan_master_wr,
   input  wire logic [`STREAM_CHANNELS-1:0][`STREAM_DATA_W-1:0] stream_chan_master_wdata,
   input  wire logic [`STREAM_CHANNELS-1:0]                     stream_chan_master_ctl,
   input  wire logic [`DC_WDATA_USED_W-1:0]                     dcache_bus_wdata,
   input  wire trace_t                                          trace,
   input  wire logic [`DBG_REG_W-1:0]                           dbg_status,
   output logic      [`DBG_REG_W-1:0]                           dbg_cmd
);

   dev_state_t s_q;
   dev_state_t s_d;
   logic       scan_rise;

   // ****************************************************************
   // Comparison vector and debug scan register
   // ****************************************************************
   always_comb begin
      s_d = s_q;

      s_d.vec = '0;

      for (int unsigned n = 0; n < `STREAM_CHANNELS; n++) begin
         s_d.vec[stream_bit(`STREAM_SCLK_BIT, n)] = stream_chan_slave_clk[n];
         s_d.vec[stream_bit(`STREAM_SRD_BIT, n)]  = stream_chan_slave_rd[n];
         s_d.vec[stream_bit(`STREAM_MCLK_BIT, n)] = stream_chan_master_clk[n];
         s_d.vec[stream_bit(`STREAM_MWR_BIT, n)]  = stream_chan_master_wr[n];
         s_d.vec[stream_bit(`STREAM_WDATA_LO, n) +: `STREAM_DATA_W] = stream_chan_master_wdata[n];
         s_d.vec[stream_bit(`STREAM_CTL_BIT, n)]  = stream_chan_master_ctl[n];
      end

      s_d.vec[`DC_WDATA_HI:`DC_WDATA_LO] =
         {{(`DC_WDATA_HI - `DC_WDATA_LO + 1 - `DC_WDATA_USED_W){1'h0}}, dcache_bus_wdata};

      s_d.vec[`TRACE_HI:`TRACE_LO] = trace;

      s_d.vec[`RSVD_HI:`RSVD_LO] = '0;

      // Scan strobe edge; the debug end makes it from sys_clk, so no sync
      s_d.scan_clk_prev = link.scan_clk;

      if (link.debug_rst) begin
         s_d.sr  = '0;
         s_d.cmd = '0;
         s_d.tdo = 1'h0;
      end else if (scan_rise && link.scan_reg_en) begin
         if (link.scan_capture) begin
            s_d.sr  = dbg_status;
            s_d.tdo = dbg_status[0];
         end else if (link.scan_shift) begin
            s_d.sr  = {link.scan_tdi, s_q.sr[`DBG_REG_W-1:1]};
            s_d.tdo = s_q.sr[1];
         end else if (link.scan_update) begin
            s_d.cmd = s_q.sr;
         end
      end
   end

   assign scan_rise = link.scan_clk && !s_q.scan_clk_prev;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign link.compare_vec = s_q.vec;
   assign link.scan_tdo    = s_q.tdo;
   assign dbg_cmd          = s_q.cmd;

endmodule

//--- rtl/lockstep_if.sv
/*
 * Link between the processor end and the debug/checker end.
 * Assumes both ends run on the same sys_clk.
 */
`timescale 1ns/1ps
`include "lockstep_cfg.svh"

interface lockstep_if;
   logic [`CMP_VEC_W-1:0] compare_vec;
   logic                  scan_clk;
   logic                  scan_tdi;
   logic                  scan_tdo;
   logic                  scan_reg_en;
   logic                  scan_shift;
   logic                  scan_capture;
   logic                  scan_update;
   logic                  debug_rst;

   modport dev (
      output compare_vec,
      output scan_tdo,
      input  scan_clk,
      input  scan_tdi,
      input  scan_reg_en,
      input  scan_shift,
      input  scan_capture,
      input  scan_update,
      input  debug_rst
   );

   modport dbg (
      input  compare_vec,
      input  scan_tdo,
      output scan_clk,
      output scan_tdi,
      output scan_reg_en,
      output scan_shift,
      output scan_capture,
      output scan_update,
      output debug_rst
   );
endinterface

//--- rtl/lockstep_pkg.sv
/*
 * Types shared by both ends: trace record, state records, helpers.
 * Assumes lockstep_cfg.svh is on the include path.
 */
`include "lockstep_cfg.svh"

package lockstep_pkg;

   // Most significant field first, so instruction lands at the slot base
   typedef struct packed {
      logic        jump_hit;
      logic        halted;
      logic        mem_piperun;
      logic        ex_piperun;
      logic        of_piperun;
      logic        icache_rdy;
      logic        icache_hit;
      logic        icache_req;
      logic        dcache_read;
      logic        dcache_rdy;
      logic        dcache_hit;
      logic        dcache_req;
      logic        data_write;
      logic        data_read;
      logic        data_access;
      logic [3:0]  data_byte_en;
      logic [31:0] data_write_value;
      logic [31:0] data_address;
      logic        delay_slot;
      logic        jump_taken;
      logic [4:0]  exception_kind;
      logic        exception_taken;
      logic [31:0] new_reg_value;
      logic [7:0]  pid_reg;
      logic [14:0] msr_reg;
      logic [4:0]  reg_addr;
      logic        reg_write;
      logic [31:0] pc;
      logic        valid_instr;
      logic [31:0] instruction;
   } trace_t;

   typedef struct packed {
      logic [`CMP_VEC_W-1:0] vec;
      logic [`DBG_REG_W-1:0] sr;
      logic [`DBG_REG_W-1:0] cmd;
      logic                  tdo;
      logic                  scan_clk_prev;
   } dev_state_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RST_HOLD,
      ST_CAP_LO,
      ST_CAP_HI,
      ST_SHIFT_LO,
      ST_SHIFT_HI,
      ST_UPD_LO,
      ST_UPD_HI
   } host_st_t;

   typedef struct packed {
      host_st_t              st;
      logic [`DBG_CNT_W-1:0] cnt;
      logic [`DBG_REG_W-1:0] tx;
      logic [`DBG_REG_W-1:0] rx;
      logic [`DBG_REG_W-1:0] rdata;
      logic                  scan_clk;
      logic                  tdi;
      logic                  reg_en;
      logic                  shift;
      logic                  capture;
      logic                  update;
      logic                  debug_rst;
      logic                  busy;
      logic                  done;
      logic                  mismatch;
   } host_state_t;

   // Absolute bit of a per-channel field
   function automatic int unsigned stream_bit(input int unsigned base, input int unsigned chan);
      stream_bit = base + chan * `STREAM_STRIDE;
   endfunction

   // Bits that take part in comparison
   function automatic logic [`CMP_VEC_W-1:0] cmp_mask();
      logic [`CMP_VEC_W-1:0] m;
      m = '1;
      for (int i = `DC_WDATA_LO + `DC_WDATA_USED_W; i <= `DC_WDATA_HI; i++) begin
         m[i] = 1'b0;
      end
      for (int i = `RSVD_LO; i <= `RSVD_HI; i++) begin
         m[i] = 1'b0;
      end
      cmp_mask = m;
   endfunction

endpackage

//--- testbench/lockstep_compare_vector_tb.sv
/* Self-checking bench joining processor and debug ends.
   Assumes the rtl package and header are compiled first. */
`timescale 1ns/1ps
`include "lockstep_cfg.svh"
module lockstep_compare_vector_tb
   import lockstep_pkg::*;
;
   logic             sys_clk;
   logic             rst;
   logic [15:0]      sclk, srd, mclk, mwr, ctl;
   logic [15:0][31:0] wd;
   logic [31:0]      dc;
   trace_t           tr;
   logic [7:0]       st, wdat;
   logic             start, rq;
   logic [4095:0]    rv;
   logic [7:0]       cmd, rdat;
   logic             busy, done, mm;
   int               n_fail, n_compared;
   lockstep_if lnk();
   lockstep_dev lockstep_dev_i (.sys_clk(sys_clk), .rst(rst), .link(lnk),
      .stream_chan_slave_clk(sclk), .stream_chan_slave_rd(srd), .stream_chan_master_clk(mclk),
      .stream_chan_master_wr(mwr), .stream_chan_master_wdata(wd), .stream_chan_master_ctl(ctl),
      .dcache_bus_wdata(dc), .trace(tr), .dbg_status(st), .dbg_cmd(cmd));
   lockstep_dbg lockstep_dbg_i (.sys_clk(sys_clk), .rst(rst), .link(lnk), .scan_start(start),
      .scan_wdata(wdat), .rst_req(rq), .ref_vec(rv), .scan_busy(busy), .scan_done(done),
      .scan_rdata(rdat), .mismatch(mm));
   lockstep_properties lockstep_properties_i (.sys_clk(sys_clk), .rst(rst),
      .compare_vec(lnk.compare_vec), .scan_clk(lnk.scan_clk), .scan_tdi(lnk.scan_tdi),
      .scan_tdo(lnk.scan_tdo), .scan_reg_en(lnk.scan_reg_en), .scan_shift(lnk.scan_shift),
      .scan_capture(lnk.scan_capture), .scan_update(lnk.scan_update), .debug_rst(lnk.debug_rst));
   // ****************************************************
   // Helpers
   // ****************************************************
   task automatic complete_run();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [4095:0] seen, input logic [4095:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %0t %s", $time, what);
      end
   endtask
   // Expected layout built from slot positions, not from the design
   function automatic logic [4095:0] exp_vec();
      logic [4095:0] v;
      v = '0;
      for (int n = 0; n < 16; n++) begin
         v[981 + 37 * n] = sclk[n];
         v[982 + 37 * n] = srd[n];
         v[983 + 37 * n] = mclk[n];
         v[984 + 37 * n] = mwr[n];
         v[985 + 37 * n +: 32] = wd[n];
         v[1017 + 37 * n] = ctl[n];
      end
      v[2906 +: 32] = dc;
      v[3551 +: 217] = tr;
      return v;
   endfunction
   task automatic wait_done();
      int i;
      for (i = 0; i < 40; i++) begin
         @(negedge sys_clk);
         if (done === 1'b1)
            break;
      end
      if (i == 40) begin
         n_fail++;
         $display("BAD %0t scan hang", $time);
         complete_run();
      end
   endtask
   // ****************************************************
   // Scenarios
   // ****************************************************
   task automatic t_stream();
      for (int k = 0; k < 3; k++) begin
         @(posedge sys_clk);
         sclk <= 16'h1234 << k;
         srd <= 16'hF00F >> k;
         mclk <= ~(16'h0F0F << k);
         mwr <= 16'h8421 << k;
         ctl <= 16'hC003 >> k;
         for (int n = 0; n < 16; n++)
            wd[n] <= 32'h8000_0001 ^ (32'(n) * 32'h0101_0101) ^ 32'(k);
         dc <= (k == 2) ? 32'hFFFF_FFFF : 32'h8000_0001 << k;
         tr <= (k == 2) ? '1 : trace_t'(217'h1 << (216 - k));
         @(posedge sys_clk);
         @(negedge sys_clk);
         chk(lnk.compare_vec, exp_vec(), "vector layout");
         chk(lnk.compare_vec[3767:3551], tr, "trace slots");
      end
   endtask
   task automatic t_mismatch();
      int b[5] = '{3768, 4095, 2938, 3417, 2906};
      logic e[5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
      for (int j = 0; j < 5; j++) begin
         @(posedge sys_clk);
         rv <= exp_vec() ^ (4096'h1 << b[j]);
         repeat (2) @(posedge sys_clk);
         @(negedge sys_clk);
         chk(mm, e[j], "masked compare");
      end
   endtask
   task automatic t_scan(input logic [7:0] w, input logic [7:0] s);
      @(posedge sys_clk);
      st <= s;
      wdat <= w;
      start <= 1'b1;
      @(posedge sys_clk);
      start <= 1'b0;
      @(negedge sys_clk);
      chk(busy, 1'b1, "scan busy");
      // Second request while busy must be dropped
      @(posedge sys_clk);
      start <= 1'b1;
      wdat <= ~w;
      @(posedge sys_clk);
      start <= 1'b0;
      wait_done();
      chk(rdat, s, "scan read");
      chk(cmd, w, "scan write");
   endtask
   task automatic t_dbgrst();
      @(posedge sys_clk);
      rq <= 1'b1;
      @(posedge sys_clk);
      rq <= 1'b0;
      @(negedge sys_clk);
      chk(lnk.debug_rst, 1'h1, "debug reset pulse");
      chk(busy, 1'h1, "busy in debug reset");
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk);
      chk(cmd, 8'h00, "debug reset");
      chk(busy, 1'b0, "idle after reset");
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   initial begin
      n_fail = 0;
      n_compared = 0;
      rst = 1'b1;
      {sclk, srd, mclk, mwr, ctl, dc, st, wdat, start, rq} = '0;
      wd = '0;
      tr = '0;
      rv = '0;
      repeat (5) @(posedge sys_clk);
      @(negedge sys_clk);
      chk(lnk.compare_vec, '0, "vector in reset");
      @(posedge sys_clk);
      rst <= 1'b0;
      t_stream();
      t_mismatch();
      t_scan(8'hA5, 8'h3C);
      t_scan(8'h5A, 8'hC3);
      t_dbgrst();
      complete_run();
   end
endmodule

//--- testbench/lockstep_properties.sv
/* Assertions on the lockstep link between processor and debug ends.
   Assumes one sys_clk domain; instantiated beside the link. */
`timescale 1ns/1ps
module lockstep_properties (
   input logic          sys_clk,
   input logic          rst,
   input logic [4095:0] compare_vec,
   input logic          scan_clk,
   input logic          scan_tdi,
   input logic          scan_tdo,
   input logic          scan_reg_en,
   input logic          scan_shift,
   input logic          scan_capture,
   input logic          scan_update,
   input logic          debug_rst
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   // ****************************************************
   // Framing sequences
   // ****************************************************
   sequence capture_s;
      scan_capture && !scan_clk ##1 scan_clk;
   endsequence
   sequence first_shift_s;
      scan_shift && !scan_clk;
   endsequence
   // ****************************************************
   // Checks
   // ****************************************************
   rsvd_clear_a: assert property (compare_vec[4095:3768] == '0)
      else $error("reserved bits set");
   dc_pad_a: assert property (compare_vec[3417:2938] == '0)
      else $error("unused data slot bits set");
   low_clear_a: assert property (compare_vec[980:0] == '0)
      else $error("bits below stream area set");
   dbg_rst_len_a: assert property ($rose(debug_rst) |-> ##[1:3] !debug_rst)
      else $error("debug reset stuck");
   phase_one_a: assert property ($onehot0({scan_shift, scan_capture, scan_update}))
      else $error("two scan phases at once");
   scan_order_a: assert property ($rose(scan_reg_en) |-> capture_s ##1 first_shift_s)
      else $error("scan not started by capture");
   upd_after_a: assert property ($rose(scan_update) |-> $past(scan_shift))
      else $error("update not after shift");
   phase_en_a: assert property ((scan_clk || scan_shift || scan_update) |-> scan_reg_en)
      else $error("scan activity without enable");
   tdo_hold_a: assert property (!scan_reg_en && !debug_rst |=> $stable(scan_tdo))
      else $error("scan output moved while disabled");
   en_len_a: assert property ($rose(scan_reg_en) |-> ##20 $fell(scan_reg_en))
      else $error("enable window length wrong");
endmodule
